// ===== rtl/tcm_access.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/100ps
// Contract
// (RULE_01) entry bits 14..10 name the source group 0..31
// (RULE_02) in connection mode bits 9..0 pick stream and channel by source rate
// (RULE_03) at 65 Mbps all ten bits are the channel, one stream
// (RULE_04) at 32 Mbps bits 9..1 channel, bit 0 stream select
// (RULE_05) at 16 Mbps bits 9..2 channel, bit 0 stream; bit 1 written zero
// (RULE_06) at 8 Mbps bits 9..3 channel, bit 0 stream; bits 2..1 zero
// (RULE_07) message mode sends bits 7..0, ignores bits 9..8
// (RULE_08) message byte leaves msb first
// (RULE_09) byte window exposes every entry low byte at consecutive addresses
// (RULE_10) one word access covers four consecutive entries
// (RULE_11) byte window is big-endian, top lane is lowest entry
// (RULE_12) each of 32 groups owns 1 KiB from 020000 in 400 steps
// (RULE_13) stream placement in a group follows the programmed output rate
// (RULE_14) 16 and 8 Mbps halves and quarters; rest of region bus error
// (RULE_15) bus error drives the active-low error output to end the cycle
// (RULE_16) window address is group start plus stream base plus timeslot
// (RULE_17) software writes zero to reserved entry bits 23..15
module tcm_access (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [23:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    output logic                 bus_error_n,
    input  wire logic            ts_valid,
    input  wire logic [4:0]      ts_group,
    input  wire logic            ts_stream,
    input  wire logic [9:0]      ts_slot,
    input  wire logic            bit_tick,
    output tcm_pkg::tcm_sel_s    sel,
    output logic                 msg_bit,
    output logic                 msg_active
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    tcm_pkg::tcm_apb_e    state;
    tcm_pkg::tcm_gctl_s   gctl [tcm_pkg::GROUPS];
    tcm_pkg::tcm_region_e rg;
    tcm_pkg::tcm_entry_s  lk_entry;
    tcm_pkg::tcm_gctl_s   src_ctl;
    logic [4:0]           acc_group;
    logic [9:0]           acc_off;
    logic                 addr_err;
    logic [12:0]          a_row;
    logic [3:0]           a_we_lo;
    logic [3:0]           a_we_hi;
    logic [59:0]          a_wdata;
    logic [59:0]          a_rdata;
    logic [59:0]          b_rdata;
    logic [12:0]          b_row;
    logic [14:0]          lk_index;
    logic                 lk_valid;
    logic [1:0]           lk_bank;
    logic [1:0]           rd_bank;
    logic [31:0]          rd_value;
    logic                 wr_commit;
    logic [10:0]          next_src;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    always_comb begin
        rg        = tcm_pkg::region(paddr);
        acc_group = 5'h00;
        acc_off   = 10'h000;
        a_row     = 13'h0000;
        if (rg == tcm_pkg::RG_LSB) begin
            acc_group = paddr[14:10]; // [RULE_12]
            acc_off   = paddr[9:0];   // [RULE_09]
            a_row     = paddr[14:2];  // [RULE_10]
        end else if (rg == tcm_pkg::RG_ENTRY) begin
            acc_group = paddr[16:12];
            acc_off   = paddr[11:2];
            a_row     = paddr[16:4];
        end
        addr_err = (rg == tcm_pkg::RG_ERR) || (rg == tcm_pkg::RG_STAT && pwrite);
        if (rg == tcm_pkg::RG_LSB || rg == tcm_pkg::RG_ENTRY) begin
            // a byte past the rate's live span has no stream behind it
            if ({1'b0, acc_off} >= tcm_pkg::region_limit(gctl[acc_group].out_rate))
                addr_err = 1'b1; // [RULE_13] [RULE_14]
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= tcm_pkg::ST_IDLE;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            bus_error_n <= 1'b1;
            prdata      <= 32'h0000_0000;
            rd_bank     <= 2'h0;
        end else begin
            unique case (state)
                tcm_pkg::ST_IDLE: begin
                    if (psel && penable) begin
                        state   <= tcm_pkg::ST_WAIT;
                        rd_bank <= paddr[3:2];
                    end
                end
                tcm_pkg::ST_WAIT: begin
                    state       <= tcm_pkg::ST_RESP;
                    pready      <= 1'b1;
                    pslverr     <= addr_err;  // [RULE_15]
                    bus_error_n <= !addr_err; // [RULE_15]
                    prdata      <= (addr_err || pwrite) ? 32'h0000_0000 : rd_value;
                end
                tcm_pkg::ST_RESP: begin
                    state       <= tcm_pkg::ST_IDLE;
                    pready      <= 1'b0;
                    pslverr     <= 1'b0;
                    bus_error_n <= 1'b1;
                    prdata      <= 32'h0000_0000;
                end
                default: state <= tcm_pkg::ST_IDLE;
            endcase
        end
    end

    // read data; reserved entry bits read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (rg)
            tcm_pkg::RG_STAT:
                rd_value = {19'h00000, sel.group, 7'h00, msg_active};
            tcm_pkg::RG_GCTL:
                rd_value = {27'h0000000, gctl[paddr[6:2]]};
            tcm_pkg::RG_LSB: // [RULE_11]
                rd_value = {a_rdata[7:0], a_rdata[22:15], a_rdata[37:30], a_rdata[52:45]};
            tcm_pkg::RG_ENTRY: // [RULE_17]
                rd_value = {17'h00000, a_rdata[15*rd_bank +: 15]};
            default:
                rd_value = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // writes land at the edge that completes the transfer
    // ------------------------------------------------------------------
    assign wr_commit = (state == tcm_pkg::ST_RESP) && psel && penable && pwrite && !pslverr;

    always_comb begin
        a_we_lo = 4'h0;
        a_we_hi = 4'h0;
        a_wdata = 60'h0;
        for (int k = 0; k < tcm_pkg::BANKS; k++) begin
            if (rg == tcm_pkg::RG_LSB) begin
                a_wdata[15*k +: 15] = {7'h00, pwdata[8*(3-k) +: 8]}; // [RULE_11]
                a_we_lo[k]          = wr_commit && pstrb[3-k];       // [RULE_10]
            end else begin
                a_wdata[15*k +: 15] = pwdata[14:0];
                a_we_lo[k] = wr_commit && (rg == tcm_pkg::RG_ENTRY) && pstrb[0]
                             && (paddr[3:2] == 2'(k));
                a_we_hi[k] = wr_commit && (rg == tcm_pkg::RG_ENTRY) && pstrb[1]
                             && (paddr[3:2] == 2'(k));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < tcm_pkg::GROUPS; g++)
                gctl[g] <= tcm_pkg::GCTL_RESET;
        end else if (wr_commit && rg == tcm_pkg::RG_GCTL && pstrb[0]) begin
            gctl[paddr[6:2]] <= pwdata[4:0];
        end
    end

    tcm_cm_ram u_ram (
        .pclk    (pclk),
        .a_row   (a_row),
        .a_we_lo (a_we_lo),
        .a_we_hi (a_we_hi),
        .a_wdata (a_wdata),
        .a_rdata (a_rdata),
        .b_row   (b_row),
        .b_rdata (b_rdata)
    );

    // ------------------------------------------------------------------
    // timeslot lookup: index, memory, decode
    // ------------------------------------------------------------------
    // stream base plus slot; slots past the stream's span are the caller's fault
    assign lk_index = {ts_group, 10'(tcm_pkg::stream_base(gctl[ts_group].out_rate, ts_stream)
                                     + ts_slot)}; // [RULE_16]
    assign b_row    = lk_index[14:2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk_valid <= 1'b0;
            lk_bank  <= 2'h0;
        end else begin
            lk_valid <= ts_valid;
            lk_bank  <= lk_index[1:0];
        end
    end

    assign lk_entry = b_rdata[15*lk_bank +: 15];
    assign src_ctl  = gctl[lk_entry.source_group_select];
    assign next_src = tcm_pkg::src_select(lk_entry.source_stream_channel_select,
                                          src_ctl.in_rate); // [RULE_02]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel <= '0;
        end else begin
            sel.valid        <= lk_valid;
            sel.message_mode <= gctl[ts_group].msg_mode;
            sel.group        <= lk_entry.source_group_select; // [RULE_01]
            sel.stream       <= next_src[10];  // [RULE_04] [RULE_05] [RULE_06]
            sel.channel      <= next_src[9:0]; // [RULE_03] [RULE_04] [RULE_05] [RULE_06]
            sel.msg_byte     <= lk_entry.source_stream_channel_select[7:0]; // [RULE_07]
        end
    end

    tcm_msg_shift u_shift (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (sel.valid && sel.message_mode),
        .load_byte  (sel.msg_byte),
        .bit_tick   (bit_tick),
        .msg_bit    (msg_bit),
        .msg_active (msg_active)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence acc_start_s;
        state == tcm_pkg::ST_IDLE && psel && penable;
    endsequence

    sequence resp_s;
        !pready ##1 pready ##1 !pready;
    endsequence

    apb_latency_a: assert property (acc_start_s |=> resp_s)
        else $error("apb answer not two cycles after access");

    err_pin_a: assert property (pready |-> (bus_error_n == !pslverr)) // [RULE_15]
        else $error("bus error pin disagrees with pslverr");

    range_err_a: assert property (acc_start_s ##0 (rg == tcm_pkg::RG_LSB) // [RULE_14]
        ##0 ({1'b0, acc_off} >= tcm_pkg::region_limit(gctl[acc_group].out_rate))
        |=> ##1 (pready && !bus_error_n))
        else $error("dead window offset not refused");

    live_ok_a: assert property (acc_start_s ##0 (rg == tcm_pkg::RG_LSB) // [RULE_13]
        ##0 (acc_off < 10'h200) ##0 (gctl[acc_group].out_rate == tcm_pkg::RATE_16M)
        |=> ##1 (pready && !pslverr))
        else $error("live window offset refused");

    big_end_a: assert property (wr_commit && rg == tcm_pkg::RG_LSB // [RULE_11]
        |-> a_we_lo[0] == pstrb[3] && a_wdata[7:0] == pwdata[31:24])
        else $error("top lane not mapped to lowest entry");

    group_field_a: assert property (lk_valid |=> sel.valid && // [RULE_01]
        sel.group == $past(b_rdata[15*lk_bank+10 +: 5]))
        else $error("source group not taken from bits 14..10");

    ch65_a: assert property (lk_valid && src_ctl.in_rate == tcm_pkg::RATE_65M // [RULE_03]
        |=> sel.channel == $past(lk_entry.source_stream_channel_select) && !sel.stream)
        else $error("65 Mbps channel wrong");

    ch32_a: assert property (lk_valid && src_ctl.in_rate == tcm_pkg::RATE_32M // [RULE_04]
        |=> sel.channel[8:0] == $past(lk_entry.source_stream_channel_select[9:1])
            && sel.stream == $past(lk_entry.source_stream_channel_select[0]))
        else $error("32 Mbps channel or stream wrong");

    ch8_a: assert property (lk_valid && src_ctl.in_rate == tcm_pkg::RATE_8M // [RULE_06]
        |=> sel.channel == {3'h0, $past(lk_entry.source_stream_channel_select[9:3])})
        else $error("8 Mbps channel wrong");

    msg_byte_a: assert property (ts_valid ##1 lk_valid // [RULE_07]
        |=> sel.msg_byte == $past(lk_entry.source_stream_channel_select[7:0]))
        else $error("message byte not bits 7..0");

endmodule

// ===== rtl/tcm_pkg.sv
package tcm_pkg;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_8M  = 2'b00,
        RATE_16M = 2'b01,
        RATE_32M = 2'b10,
        RATE_65M = 2'b11
    } tcm_rate_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RESP = 2'b10
    } tcm_apb_e;

    typedef enum logic [2:0] {
        RG_ERR   = 3'b000,
        RG_STAT  = 3'b001,
        RG_GCTL  = 3'b010,
        RG_LSB   = 3'b011,
        RG_ENTRY = 3'b100
    } tcm_region_e;

    typedef struct packed {
        logic [4:0] source_group_select;
        logic [9:0] source_stream_channel_select;
    } tcm_entry_s;

    typedef struct packed {
        logic      msg_mode;
        tcm_rate_e in_rate;
        tcm_rate_e out_rate;
    } tcm_gctl_s;

    typedef struct packed {
        logic       valid;
        logic       message_mode;
        logic [4:0] group;
        logic       stream;
        logic [9:0] channel;
        logic [7:0] msg_byte;
    } tcm_sel_s;

    // ------------------------------------------------------------------
    // address map and reset values
    // ------------------------------------------------------------------
    localparam logic [23:0] STATUS_ADDR = 24'h000004;
    localparam logic [23:0] GCTL_BASE   = 24'h000100;
    localparam logic [23:0] GCTL_END    = 24'h00017c;
    localparam logic [23:0] LSB_BASE    = 24'h020000;
    localparam logic [23:0] LSB_END     = 24'h027fff;
    localparam logic [23:0] ENTRY_BASE  = 24'h040000;
    localparam logic [23:0] ENTRY_END   = 24'h05ffff;
    localparam logic [4:0]  GCTL_RESET  = 5'h0f;
    localparam int          GROUPS      = 32;
    localparam int          BANKS       = 4;
    localparam int          ROWS        = 8192;
    localparam logic [2:0]  LAST_BIT    = 3'h7;

    // ------------------------------------------------------------------
    // rate dependent layout
    // ------------------------------------------------------------------
    function automatic logic [10:0] region_limit(input tcm_rate_e r);
        unique case (r)
            RATE_65M: region_limit = 11'h400;
            RATE_32M: region_limit = 11'h400;
            RATE_16M: region_limit = 11'h200;
            RATE_8M:  region_limit = 11'h100;
        endcase
    endfunction

    function automatic logic [9:0] stream_base(input tcm_rate_e r, input logic second);
        unique case (r)
            RATE_65M: stream_base = 10'h000;
            RATE_32M: stream_base = second ? 10'h200 : 10'h000;
            RATE_16M: stream_base = second ? 10'h100 : 10'h000;
            RATE_8M:  stream_base = second ? 10'h080 : 10'h000;
        endcase
    endfunction

    // returns {stream, channel}
    function automatic logic [10:0] src_select(input logic [9:0] f, input tcm_rate_e r);
        unique case (r)
            RATE_65M: src_select = {1'b0, f};
            RATE_32M: src_select = {f[0], 1'b0, f[9:1]};
            RATE_16M: src_select = {f[0], 2'h0, f[9:2]};
            RATE_8M:  src_select = {f[0], 3'h0, f[9:3]};
        endcase
    endfunction

    function automatic tcm_region_e region(input logic [23:0] a);
        if (a[1:0] != 2'h0)
            region = RG_ERR;
        else if (a == STATUS_ADDR)
            region = RG_STAT;
        else if (a >= GCTL_BASE && a <= GCTL_END)
            region = RG_GCTL;
        else if (a >= LSB_BASE && a <= LSB_END)
            region = RG_LSB;
        else if (a >= ENTRY_BASE && a <= ENTRY_END)
            region = RG_ENTRY;
        else
            region = RG_ERR;
    endfunction

endpackage

// ===== rtl/tcm_cm_ram.sv
`timescale 1ns/100ps
module tcm_cm_ram (
    input  wire logic        pclk,
    input  wire logic [12:0] a_row,
    input  wire logic [3:0]  a_we_lo,
    input  wire logic [3:0]  a_we_hi,
    input  wire logic [59:0] a_wdata,
    output logic      [59:0] a_rdata,
    input  wire logic [12:0] b_row,
    output logic      [59:0] b_rdata
);

    // ------------------------------------------------------------------
    // four banks so one word write can touch four entries at once
    // ------------------------------------------------------------------
    logic [14:0] mem [tcm_pkg::BANKS][tcm_pkg::ROWS];

    always_ff @(posedge pclk) begin
        for (int k = 0; k < tcm_pkg::BANKS; k++) begin
            if (a_we_lo[k])
                mem[k][a_row][7:0] <= a_wdata[15*k +: 8];
            if (a_we_hi[k])
                mem[k][a_row][14:8] <= a_wdata[15*k+8 +: 7];
            a_rdata[15*k +: 15] <= mem[k][a_row];
            b_rdata[15*k +: 15] <= mem[k][b_row];
        end
    end

endmodule

// ===== rtl/tcm_msg_shift.sv
`timescale 1ns/100ps
module tcm_msg_shift (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [7:0] load_byte,
    input  wire logic       bit_tick,
    output logic            msg_bit,
    output logic            msg_active
);

    logic [7:0] shreg;
    logic [2:0] cnt;

    // ------------------------------------------------------------------
    // serialiser
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg      <= 8'h00;
            cnt        <= 3'h0;
            msg_active <= 1'b0;
        end else if (load) begin
            shreg      <= load_byte; // [RULE_08]
            cnt        <= 3'h0;
            msg_active <= 1'b1;
        end else if (bit_tick && msg_active) begin
            shreg      <= {shreg[6:0], 1'b0}; // [RULE_08]
            cnt        <= cnt + 3'h1;
            msg_active <= (cnt != tcm_pkg::LAST_BIT);
        end
    end

    assign msg_bit = shreg[7];

    msb_first_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
        load |=> msg_bit == $past(load_byte[7]))
        else $error("message byte not sent msb first");

endmodule

// ===== testbench/tcm_host_model.sv
`timescale 1ns/100ps
module tcm_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [23:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        bus_error_n
);
    // ------------------------------------------------------------------
    // apb master
    // ------------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 24'h000000;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
    end

    // e = {pslverr, error line low}; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic [1:0] e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= a[18] ? (d & 32'hff007fff) : d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = {pslverr, ~bus_error_n};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, bus_error_n;
    logic [23:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb;
    logic [1:0]        er;
    logic              ts_valid, ts_stream, bit_tick, msg_bit, msg_active;
    logic [4:0]        ts_group;
    logic [9:0]        ts_slot;
    tcm_pkg::tcm_sel_s sel;
    int                error_cnt = 0;
    int                total_checks = 0;

    always #4 pclk = ~pclk;

    tcm_host_model u_tcm_host_model (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_error_n(bus_error_n));

    tcm_access u_tcm_access (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_error_n(bus_error_n),
        .ts_valid(ts_valid), .ts_group(ts_group), .ts_stream(ts_stream), .ts_slot(ts_slot),
        .bit_tick(bit_tick), .sel(sel), .msg_bit(msg_bit), .msg_active(msg_active));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_err(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: bus status %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] d, input logic [1:0] e);
        u_tcm_host_model.xfer(1'b1, a, d, rd, er);
        chk_err(er, e);
    endtask

    // mask hides entry bits that were never written
    task automatic rdc(input logic [23:0] a, input logic [31:0] x, input logic [31:0] m,
                       input logic [1:0] e);
        u_tcm_host_model.xfer(1'b0, a, 32'h00000000, rd, er);
        chk_err(er, e);
        if (e == 2'b00) begin
            chk_val(rd & m, x);
        end
    endtask

    // answer is fixed at two cycles after the request
    task automatic look(input logic [4:0] g, input logic s, input logic [9:0] t);
        @(posedge pclk);
        ts_valid <= 1'b1;
        ts_group <= g;
        ts_stream <= s;
        ts_slot <= t;
        @(posedge pclk);
        ts_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        chk_val(32'(sel.valid), 32'h1);
    endtask

    task automatic tdone(input string name);
        $display("test %s done at %0t", name, $time);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        $display("Error at %0t: run did not finish", $time);
        print_verdict;
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        ts_valid = 1'b0;
        ts_group = 5'h00;
        ts_stream = 1'b0;
        ts_slot = 10'h000;
        bit_tick = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(24'h000100, 32'h0000000f, 32'hffffffff, 2'b00);
        tdone("reset");
        // group 2 out 32M; source group 5 rate swept
        wr(24'h000108, 32'h0000000e, 2'b00);
        wr(24'h04280c, 32'hff0017c1, 2'b00);
        rdc(24'h04280c, 32'h000017c1, 32'hffffffff, 2'b00);
        for (int r = 0; r < 4; r++) begin
            wr(24'h000114, {27'h0, 1'b0, 2'(r), 2'b11}, 2'b00);
            look(5'h02, 1'b1, 10'h003);
            chk_val(32'(sel.group), 32'h5);
            chk_val(32'(sel.channel), 32'(10'h3c1 >> (3 - r)));
            chk_val(32'(sel.stream), (r == 3) ? 32'h0 : 32'h1);
            chk_val(32'(sel.message_mode), 32'h0);
        end
        rdc(24'h000004, 32'h00000500, 32'hffffffff, 2'b00);
        wr(24'h000004, 32'h00000000, 2'b11);
        tdone("decode");
        wr(24'h020a00, 32'ha1b2c3d4, 2'b00);
        rdc(24'h020a00, 32'ha1b2c3d4, 32'hffffffff, 2'b00);
        for (int i = 0; i < 4; i++) begin
            rdc(24'h042800 + 24'(4 * i), (32'ha1b2c3d4 >> (24 - 8 * i)) & 32'hff,
                32'hff, 2'b00);
        end
        tdone("byte window");
        wr(24'h000108, 32'h0000001e, 2'b00);
        wr(24'h042804, 32'h000003b2, 2'b00);
        look(5'h02, 1'b1, 10'h001);
        chk_val(32'(sel.message_mode), 32'h1);
        chk_val(32'(sel.msg_byte), 32'hb2);
        for (int b = 7; b >= 0; b--) begin
            @(posedge pclk);
            chk_val({30'h0, msg_active, msg_bit}, {31'h1, 1'(8'hb2 >> b)});
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
        end
        @(posedge pclk);
        chk_val(32'(msg_active), 32'h0);
        tdone("message");
        // group 3 out 8M then 16M
        wr(24'h00010c, 32'h0000000c, 2'b00);
        // whole entry first so the lookup sees no unknown group bits
        wr(24'h043200, 32'h00000000, 2'b00);
        wr(24'h020c80, 32'h5a000000, 2'b00);
        look(5'h03, 1'b1, 10'h000);
        chk_val(32'(sel.msg_byte), 32'h5a);
        wr(24'h020cfc, 32'h00000000, 2'b00);
        wr(24'h020d00, 32'h00000000, 2'b11);
        wr(24'h043400, 32'h00000000, 2'b11);
        wr(24'h00010c, 32'h0000000d, 2'b00);
        wr(24'h020dfc, 32'h00000000, 2'b00);
        rdc(24'h020e00, 32'h0, 32'h0, 2'b11);
        tdone("rate limits");
        wr(24'h05fff0, 32'h00000000, 2'b00);
        wr(24'h027ffc, 32'h01020304, 2'b00);
        rdc(24'h027ffc, 32'h01020304, 32'hffffffff, 2'b00);
        look(5'h1f, 1'b1, 10'h3fc);
        chk_val(32'(sel.msg_byte), 32'h01);
        rdc(24'h030000, 32'h0, 32'h0, 2'b11);
        wr(24'h020002, 32'h00000000, 2'b11);
        tdone("map edges");
        print_verdict;
    end
endmodule
